// ==== logic/touch_key_map.svh ====
// Register offsets, field positions, reset values and counts of the touch key block
`ifndef TOUCH_KEY_MAP_SVH
`define TOUCH_KEY_MAP_SVH
// ==========================================
// Global register addresses
`define TK_ADDR_PRELOAD 8'h00
`define TK_ADDR_CTRL0 8'h01
`define TK_ADDR_CTRL1 8'h02
`define TK_ADDR_REF_LO 8'h03
`define TK_ADDR_REF_HI 8'h04
// ==========================================
// Module register block: addr[7:4] = first + module, addr[3:0] = offset
`define TK_MOD_FIRST 4'h1
`define TK_MOD_LAST 4'h4
`define TK_MOD_CNT_LO 4'h0
`define TK_MOD_CNT_HI 4'h1
`define TK_MOD_TRIM_LO 4'h2
`define TK_MOD_TRIM_HI 4'h3
`define TK_MOD_CTRL0 4'h4
`define TK_MOD_CTRL1 4'h5
// ==========================================
// Field positions
`define TK_C0_SLOT_OVF 6
`define TK_C0_START 5
`define TK_C0_CAP_OVF 4
`define TK_C0_REF_OVF 3
`define TK_C0_SHARE 2
`define TK_MC0_MUX_MSB 7
`define TK_MC0_MUX_LSB 6
`define TK_MC1_SLOT_CLK 7
`define TK_MC1_ROEN 5
`define TK_MC1_KOEN 4
`define TK_MC1_MASK 8'hbf
// ==========================================
// Reset values and counts
`define TK_FREQ_RESET 2'h3
`define TK_UNIT_LAST 5'h1f
`define TK_SLOT_LAST 8'hff
`define TK_CNT_LAST 16'hffff
`define TK_DIV4_LAST 2'h3
`endif

// ==== logic/touch_key_pkg.sv ====
// State types of the touch key block
`default_nettype none
package touch_key_pkg;
  typedef struct packed {
    logic [4:0] unit;
    logic [7:0] slot;
    logic [15:0] cnt;
    logic run;
  } slot_state_t;
  typedef struct packed {
    logic [7:0] preload;
    logic start;
    logic start_prev;
    logic slot_ovf;
    logic cap_ovf;
    logic ref_ovf;
    logic share;
    logic [1:0] ref_sel;
    logic [1:0] freq_sel;
    logic run_prev;
    logic irq;
    logic [15:0] ref_cnt;
    logic [2:0] div;
    logic [3:0][9:0] trim;
    logic [3:0][7:0] mc0;
    logic [3:0][7:0] mc1;
    logic [7:0] rdata;
  } top_state_t;
endpackage
`default_nettype wire

// ==== logic/osc_edge_sync.sv ====
// Two-flop synchroniser with rising edge pulse for oscillator inputs
`timescale 1ns/1ps
`default_nettype none
module osc_edge_sync #(
  parameter int W = 20
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [W-1:0] async_in, // Oscillator levels
  output logic [W-1:0] rise // One pulse per rising edge
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] rise;
  } sync_state_t;
  sync_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    state_d.s1 = async_in;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    state_d.rise = state_q.s2 & ~state_q.s3;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rise = state_q.rise;
endmodule // osc_edge_sync
`default_nettype wire

// ==== logic/touch_slot_counter.sv ====
// Per-module time slot counter and key cycle counter
`timescale 1ns/1ps
`default_nettype none
`include "touch_key_map.svh"
module touch_slot_counter (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic start, // Detect start level
  input wire logic start_rise, // Start rising edge pulse
  input wire logic stop, // Selected slot overflow
  input wire logic slot_tick, // Slot clock pulse
  input wire logic key_tick, // Selected key oscillator pulse
  input wire logic [7:0] preload, // Slot preload value
  output logic run, // Window active
  output logic [15:0] count, // Key cycle count
  output logic slot_ovf, // Slot overflow pulse
  output logic cap_ovf // Key count overflow pulse
);
  touch_key_pkg::slot_state_t state_q, state_d;

  assign slot_ovf = state_q.run & slot_tick & (state_q.unit == `TK_UNIT_LAST)
                    & (state_q.slot == `TK_SLOT_LAST);
  assign cap_ovf = state_q.run & key_tick & (state_q.cnt == `TK_CNT_LAST);

  always_comb begin
    state_d = state_q;
    if (!start) begin
      // Slot counter keeps its value while idle
      state_d.unit = 5'h00;
      state_d.cnt = 16'h0000;
      state_d.run = 1'b0;
    end else if (start_rise) begin
      state_d.run = 1'b1;
      state_d.slot = preload;
      state_d.unit = 5'h00;
      state_d.cnt = 16'h0000;
    end else if (state_q.run) begin
      if (slot_tick) begin
        state_d.unit = state_q.unit + 5'h01;
        if (state_q.unit == `TK_UNIT_LAST) begin
          state_d.slot = state_q.slot + 8'h01;
        end
      end
      if (key_tick) begin
        state_d.cnt = state_q.cnt + 16'h0001;
      end
      if (stop) begin
        state_d.run = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign run = state_q.run;
  assign count = state_q.cnt;
endmodule // touch_slot_counter
`default_nettype wire

// ==== logic/touch_key_slot_counters.sv ====
// Touch key measurement block: four modules, reference counter and registers
// Notes on behaviour
// - Unit period is 32 slot clocks
// - Slot overflows after (256-preload)*32 clocks
// - Slot overflow that stops the last running module sets flag and interrupt request
// - Software set of flag raises no request
// - Overflow stops the module's oscillators and counters; reference counter stops with the last module
// - Share bit selects module 0 slot counter
// - Start low clears counters, slot kept
// - Start rising edge begins detection window
// - Key counter overflow sets sticky flag
// - Reference counter overflow sets sticky flag
// - Reference clock is system clock /1,2,4,8
// - Oscillator frequency select resets to 11
// - Reference counter byte pair, holds after overflow
// - Key counters hold, read-only byte pair
// - Reference counter counts during window
// - Unused control1 bits read zero
// - Slot clock: reference osc or sysclk/4
// - Key select picks one of four keys
`timescale 1ns/1ps
`default_nettype none
`include "touch_key_map.svh"
module touch_key_slot_counters (
  input wire logic ref_clk, // System clock, 10 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic [15:0] key_osc, // Key oscillator outputs
  input wire logic [3:0] ref_osc, // Reference oscillator outputs
  output logic [3:0] key_osc_en, // Key oscillator run, per module
  output logic [3:0] ref_osc_en, // Reference oscillator run, per module
  output logic [15:0] key_pad_en, // Key pad enables
  output logic [7:0] key_mux_sel, // Key select, two bits per module
  output logic [39:0] ref_cap_trim, // Reference capacitor trim, ten bits per module
  output logic [1:0] osc_freq_sel, // Oscillator frequency code
  output logic touch_irq_request // Interrupt request pulse
);
  touch_key_pkg::top_state_t state_q, state_d;

  logic [15:0] key_rise;
  logic [3:0] ref_rise;
  logic [3:0] slot_tick;
  logic [3:0] key_tick;
  logic [3:0] slot_ovf;
  logic [3:0] cap_ovf;
  logic [3:0] mod_run;
  logic [3:0] stop;
  logic [3:0][15:0] cap_cnt;
  logic run_any;
  logic done;
  logic start_rise;
  logic div4_tick;
  logic ref_tick;
  logic [2:0] ref_mask;
  logic mod_hit;
  logic [1:0] mod_idx;

  // ==========================================
  // Oscillator synchronisers
  osc_edge_sync #(
    .W(20)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({ref_osc, key_osc}),
    .rise({ref_rise, key_rise})
  );

  // ==========================================
  // Clock enables
  assign div4_tick = state_q.div[1:0] == `TK_DIV4_LAST;

  always_comb begin
    case (state_q.ref_sel)
      2'h0: ref_mask = 3'h0;
      2'h1: ref_mask = 3'h1;
      2'h2: ref_mask = 3'h3;
      default: ref_mask = 3'h7;
    endcase
  end

  assign ref_tick = (state_q.div & ref_mask) == ref_mask;

  // ==========================================
  // Touch modules
  genvar g;
  for (g = 0; g < 4; g++) begin : g_mod
    assign key_tick[g] = key_rise[{2'(g),
      state_q.mc0[g][`TK_MC0_MUX_MSB:`TK_MC0_MUX_LSB]}];
    assign slot_tick[g] = state_q.mc1[g][`TK_MC1_SLOT_CLK] ? div4_tick : ref_rise[g];
    assign stop[g] = state_q.share ? slot_ovf[0] : slot_ovf[g];
    assign key_osc_en[g] = mod_run[g] & state_q.mc1[g][`TK_MC1_KOEN];
    assign ref_osc_en[g] = mod_run[g] & state_q.mc1[g][`TK_MC1_ROEN];
    assign key_pad_en[g*4 +: 4] = state_q.mc1[g][3:0];
    assign key_mux_sel[g*2 +: 2] = state_q.mc0[g][`TK_MC0_MUX_MSB:`TK_MC0_MUX_LSB];
    assign ref_cap_trim[g*10 +: 10] = state_q.trim[g];

    touch_slot_counter u_slot (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(state_q.start),
      .start_rise(start_rise),
      .stop(stop[g]),
      .slot_tick(slot_tick[g]),
      .key_tick(key_tick[g]),
      .preload(state_q.preload),
      .run(mod_run[g]),
      .count(cap_cnt[g]),
      .slot_ovf(slot_ovf[g]),
      .cap_ovf(cap_ovf[g])
    );
  end

  assign run_any = |mod_run;
  assign start_rise = state_q.start & ~state_q.start_prev;
  // Window ends by overflow, not by software clearing start
  assign done = state_q.run_prev & ~run_any & state_q.start;
  assign mod_hit = (addr[7:4] >= `TK_MOD_FIRST) && (addr[7:4] <= `TK_MOD_LAST);
  assign mod_idx = 2'(addr[7:4] - `TK_MOD_FIRST);

  // ==========================================
  // Next state
  always_comb begin
    state_d = state_q;
    state_d.start_prev = state_q.start;
    state_d.run_prev = run_any;
    state_d.div = state_q.div + 3'h1;
    state_d.irq = 1'b0;
    state_d.rdata = 8'h00;

    if (!state_q.start) begin
      state_d.ref_cnt = 16'h0000;
    end else if (run_any && ref_tick) begin
      state_d.ref_cnt = state_q.ref_cnt + 16'h0001;
    end

    if (wr) begin
      case (addr)
        `TK_ADDR_PRELOAD: begin
          state_d.preload = wdata;
        end
        `TK_ADDR_CTRL0: begin
          state_d.slot_ovf = wdata[`TK_C0_SLOT_OVF];
          state_d.start = wdata[`TK_C0_START];
          state_d.cap_ovf = wdata[`TK_C0_CAP_OVF];
          state_d.ref_ovf = wdata[`TK_C0_REF_OVF];
          state_d.share = wdata[`TK_C0_SHARE];
          state_d.ref_sel = wdata[1:0];
        end
        `TK_ADDR_CTRL1: begin
          state_d.freq_sel = wdata[1:0];
        end
        default: begin
          if (mod_hit) begin
            case (addr[3:0])
              `TK_MOD_TRIM_LO: state_d.trim[mod_idx][7:0] = wdata;
              `TK_MOD_TRIM_HI: state_d.trim[mod_idx][9:8] = wdata[1:0];
              `TK_MOD_CTRL0: state_d.mc0[mod_idx] = wdata;
              `TK_MOD_CTRL1: state_d.mc1[mod_idx] = wdata & `TK_MC1_MASK;
              default: begin
              end
            endcase
          end
        end
      endcase
    end

    // Hardware set wins over a clearing write
    if (done) begin
      state_d.slot_ovf = 1'b1;
      state_d.irq = 1'b1;
    end
    if (|cap_ovf) begin
      state_d.cap_ovf = 1'b1;
    end
    if (state_q.start && run_any && ref_tick && (state_q.ref_cnt == `TK_CNT_LAST)) begin
      state_d.ref_ovf = 1'b1;
    end

    if (rd) begin
      case (addr)
        `TK_ADDR_PRELOAD: state_d.rdata = state_q.preload;
        `TK_ADDR_CTRL0: state_d.rdata = {1'b0, state_q.slot_ovf, state_q.start,
          state_q.cap_ovf, state_q.ref_ovf, state_q.share, state_q.ref_sel};
        `TK_ADDR_CTRL1: state_d.rdata = {6'h00, state_q.freq_sel};
        `TK_ADDR_REF_LO: state_d.rdata = state_q.ref_cnt[7:0];
        `TK_ADDR_REF_HI: state_d.rdata = state_q.ref_cnt[15:8];
        default: begin
          if (mod_hit) begin
            case (addr[3:0])
              `TK_MOD_CNT_LO: state_d.rdata = cap_cnt[mod_idx][7:0];
              `TK_MOD_CNT_HI: state_d.rdata = cap_cnt[mod_idx][15:8];
              `TK_MOD_TRIM_LO: state_d.rdata = state_q.trim[mod_idx][7:0];
              `TK_MOD_TRIM_HI: state_d.rdata = {6'h00, state_q.trim[mod_idx][9:8]};
              `TK_MOD_CTRL0: state_d.rdata = state_q.mc0[mod_idx];
              `TK_MOD_CTRL1: state_d.rdata = state_q.mc1[mod_idx];
              default: state_d.rdata = 8'h00;
            endcase
          end
        end
      endcase
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= '0;
      state_q.freq_sel <= `TK_FREQ_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata = state_q.rdata;
  assign osc_freq_sel = state_q.freq_sel;
  assign touch_irq_request = state_q.irq;

  // ==========================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence sel8_s;
    (ref_tick && state_q.ref_sel == 2'h3) ##1 (state_q.ref_sel == 2'h3) [*7];
  endsequence

  sequence window_start_s;
    start_rise ##1 (mod_run == 4'hf);
  endsequence

  irq_on_done_a: assert property (done |=> (touch_irq_request && state_q.slot_ovf))
    else $error("slot overflow did not raise flag and request");
  sw_set_quiet_a: assert property ((wr && addr == `TK_ADDR_CTRL0
    && wdata[`TK_C0_SLOT_OVF] && !done) |=> !touch_irq_request)
    else $error("software flag set raised a request");
  osc_stop_a: assert property (!run_any |-> (key_osc_en == 4'h0 && ref_osc_en == 4'h0))
    else $error("oscillator enabled outside window");
  share_stop_a: assert property ((state_q.share && slot_ovf[0]) |=> !run_any)
    else $error("shared slot overflow did not stop all modules");
  idle_clear_a: assert property (!state_q.start |=> (state_q.ref_cnt == 16'h0000
    && cap_cnt == '0))
    else $error("counters not cleared while idle");
  window_open_a: assert property (window_start_s |-> (key_osc_en == {
    state_q.mc1[3][`TK_MC1_KOEN], state_q.mc1[2][`TK_MC1_KOEN],
    state_q.mc1[1][`TK_MC1_KOEN], state_q.mc1[0][`TK_MC1_KOEN]} && ref_osc_en == {
    state_q.mc1[3][`TK_MC1_ROEN], state_q.mc1[2][`TK_MC1_ROEN],
    state_q.mc1[1][`TK_MC1_ROEN], state_q.mc1[0][`TK_MC1_ROEN]}))
    else $error("window start did not enable oscillators");
  run_start_a: assert property (start_rise |=> (mod_run == 4'hf))
    else $error("start edge did not start every module");
  start_low_stop_a: assert property (!state_q.start |=> (mod_run == 4'h0))
    else $error("module kept running with start low");
  irq_pulse_a: assert property (touch_irq_request |=> !touch_irq_request)
    else $error("interrupt request longer than one cycle");
  cap_ovf_a: assert property ((|cap_ovf) |=> state_q.cap_ovf)
    else $error("key counter overflow flag not set");
  ref_gate_a: assert property ((state_q.start && !ref_tick) |=> $stable(state_q.ref_cnt))
    else $error("reference counter moved without a clock enable");
  ref_hold_a: assert property ((state_q.start && !run_any && !start_rise)
    |=> $stable(state_q.ref_cnt))
    else $error("reference counter moved after overflow");
  ref_ovf_a: assert property ((state_q.start && run_any && ref_tick
    && state_q.ref_cnt == 16'hffff) |=> state_q.ref_ovf)
    else $error("reference overflow flag not set");
  ref_div8_a: assert property (sel8_s |=> ref_tick)
    else $error("reference clock divide by eight wrong");
  ctrl1_read_a: assert property ((rd && addr == `TK_ADDR_CTRL1)
    |=> rdata == {6'h00, $past(state_q.freq_sel)})
    else $error("control1 read returned wrong bits");
endmodule // touch_key_slot_counters
`default_nettype wire

// ==== verification/touch_osc_model.sv ====
// Behavioural model of the key and reference oscillators
`timescale 1ns/1ps
`default_nettype none
module touch_osc_model (
  input wire logic ref_clk, // System clock
  input wire logic [3:0] key_osc_en, // Key oscillator run, per module
  input wire logic [3:0] ref_osc_en, // Reference oscillator run, per module
  output logic [15:0] key_osc, // Key oscillator levels
  output logic [3:0] ref_osc // Reference oscillator levels
);
  // ==========================================
  // Oscillators
  // Key k of a module toggles every k+2 clocks, so each key has its own rate
  int kc [16];
  int rc [4];
  initial begin
    key_osc = 16'h0000;
    ref_osc = 4'h0;
    for (int i = 0; i < 16; i++) kc[i] = 0;
    for (int i = 0; i < 4; i++) rc[i] = 0;
  end
  always @(posedge ref_clk) begin
    for (int i = 0; i < 16; i++) begin
      // A stopped oscillator stands still
      if (key_osc_en[i / 4] !== 1'b1) begin
        kc[i] <= 0;
      end else if (kc[i] >= (i % 4) + 1) begin
        kc[i] <= 0;
        key_osc[i] <= ~key_osc[i];
      end else begin
        kc[i] <= kc[i] + 1;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (ref_osc_en[i] !== 1'b1) begin
        rc[i] <= 0;
      end else if (rc[i] >= 2) begin
        rc[i] <= 0;
        ref_osc[i] <= ~ref_osc[i];
      end else begin
        rc[i] <= rc[i] + 1;
      end
    end
  end
endmodule // touch_osc_model
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking testbench of the touch key measurement block
`timescale 1ns/1ps
`default_nettype none
`include "touch_key_map.svh"
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [15:0] key_osc;
  logic [3:0] ref_osc;
  logic [3:0] key_osc_en;
  logic [3:0] ref_osc_en;
  logic [15:0] key_pad_en;
  logic [7:0] key_mux_sel;
  logic [39:0] ref_cap_trim;
  logic [1:0] osc_freq_sel;
  logic touch_irq_request;
  int failures = 0;
  int compares = 0;
  int irqs = 0;
  int cycles = 0;
  logic [15:0] v;
  logic seen;
  int base;
  always #50 ref_clk = ~ref_clk;
  touch_key_slot_counters dut_u (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .key_osc(key_osc), .ref_osc(ref_osc),
    .key_osc_en(key_osc_en), .ref_osc_en(ref_osc_en), .key_pad_en(key_pad_en),
    .key_mux_sel(key_mux_sel), .ref_cap_trim(ref_cap_trim), .osc_freq_sel(osc_freq_sel),
    .touch_irq_request(touch_irq_request));
  touch_osc_model osc_u (.ref_clk(ref_clk), .key_osc_en(key_osc_en), .ref_osc_en(ref_osc_en),
    .key_osc(key_osc), .ref_osc(ref_osc));
  // ==========================================
  // Reporting
  task automatic results();
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
    logic ok;
    ok = (got + tol >= exp) && (got <= exp + tol);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycle count, interrupt pulses and hang limit
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (touch_irq_request === 1'b1) irqs <= irqs + 1;
    if (cycles == 80000) begin
      failures = failures + 1;
      results();
    end
  end
  // ==========================================
  // Register bus
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    // Let the register update settle before anyone looks at outputs
    @(negedge ref_clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd_reg(a, d[7:0]);
    rd_reg(a + 8'h01, d[15:8]);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] b;
    rd_reg(a, b);
    chk({8'h00, b}, {8'h00, exp}, 0);
  endtask
  task automatic wait_irq(input int n, output logic s);
    int b0;
    b0 = irqs;
    s = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      if (irqs != b0) s = 1'b1;
    end
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(`TK_ADDR_CTRL1, 8'h03);
    chk({14'h0000, osc_freq_sel}, 16'h0003, 0);
    rd_chk(`TK_ADDR_CTRL0, 8'h00);
    wr_reg(`TK_ADDR_CTRL1, 8'hfc);
    rd_chk(`TK_ADDR_CTRL1, 8'h00);
    chk({14'h0000, osc_freq_sel}, 16'h0000, 0);
    wr_reg(8'h13, 8'hff);
    rd_chk(8'h13, 8'h03);
    chk({6'h00, ref_cap_trim[9:0]}, 16'h0300, 0);
    wr_reg(8'h10, 8'h5a);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'hf0, 8'h00);
    wr_reg(`TK_ADDR_PRELOAD, 8'hfe);
    rd_chk(`TK_ADDR_PRELOAD, 8'hfe);
    wr_reg(8'h15, 8'hff);
    rd_chk(8'h15, 8'hbf);
    chk({12'h000, key_pad_en[3:0]}, 16'h000f, 0);
    wr_reg(8'h15, 8'hb0);
    for (int n = 2; n < 5; n++) wr_reg({4'(n), 4'h5}, 8'h10);
    // Shared slot counter of module 0, clocked at sysclk/4: window is 2*32*4 clocks
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h14, 8'(c << 6));
      chk({14'h0000, key_mux_sel[1:0]}, 16'(c), 0);
      wr_reg(`TK_ADDR_CTRL0, 8'(8'h04 | c));
      wr_reg(`TK_ADDR_CTRL0, 8'(8'h24 | c));
      wait_irq(400, seen);
      chk({15'h0000, seen}, 16'h0001, 0);
      chk({8'h00, key_osc_en, ref_osc_en}, 16'h0000, 0);
      rd_chk(`TK_ADDR_CTRL0, 8'(8'h64 | c));
      rd16(`TK_ADDR_REF_LO, v);
      chk(v, 16'h0100 >> c, 4);
      rd16(8'h10, v);
      chk(v, 16'(128 / (c + 2)), 2);
    end
    wr_reg(`TK_ADDR_CTRL0, 8'h00);
    rd16(`TK_ADDR_REF_LO, v);
    chk(v, 16'h0000, 0);
    rd16(8'h10, v);
    chk(v, 16'h0000, 0);
    rd_chk(`TK_ADDR_PRELOAD, 8'hfe);
    // Flag set by software raises no request
    base = irqs;
    wr_reg(`TK_ADDR_CTRL0, 8'h40);
    repeat (5) @(posedge ref_clk);
    chk(16'(irqs - base), 16'h0000, 0);
    rd_chk(`TK_ADDR_CTRL0, 8'h40);
    // Own slot counters: modules 1 to 3 never tick, so no overflow ends the window
    wr_reg(`TK_ADDR_CTRL0, 8'h00);
    wr_reg(`TK_ADDR_CTRL0, 8'h20);
    wait_irq(66000, seen);
    chk({15'h0000, seen}, 16'h0000, 0);
    chk({12'h000, key_osc_en}, 16'h000e, 0);
    rd_chk(`TK_ADDR_CTRL0, 8'h28);
    wr_reg(`TK_ADDR_CTRL0, 8'h00);
    @(negedge ref_clk);
    chk({12'h000, key_osc_en}, 16'h0000, 0);
    results();
  end
endmodule // tb
`default_nettype wire
